// *** hdl/wsc_device.sv ***
// One cascaded search device running 272-bit searches over four-entry pages.
// Assumes clk is the double-rate command clock and config inputs are static.
`timescale 1ns/100ps
module wsc_device
    import wsc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    wsc_link_if.device                 link,
    input  wire logic [1:0]            tableSizeSel,
    input  wire logic [2:0]            hitLatencySel,
    input  wire logic [7:0]            widthCfg,
    input  wire logic                  defaultSramDriver,
    input  wire logic                  defaultFlagDriver,
    input  wire logic                  localHitIn,
    input  wire logic                  blockHitIn,
    output logic                       localHitOut,
    output logic                       blockHitOut,
    input  wire logic                  entryWrite,
    input  wire logic [PAGE_W-1:0]     entryPage,
    input  wire logic [KEY_W-1:0]      entryData,
    input  wire logic [KEY_W-1:0]      entryMask,
    input  wire logic                  gmrWrite,
    input  wire logic [2:0]            gmrIndex,
    input  wire logic [HALF_W-1:0]     gmrData,
    input  wire logic [2:0]            resultSel,
    output logic [SRAM_ADDRESS_OUT_W-1:0]          resultAddr,
    output logic                       resultHit
);
    import wsc_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_WORD_B, S_WORD_C, S_WORD_D} wsc_dev_state_t;

    wsc_dev_state_t stateQ, stateD;
    wsc_word_t      wordAQ, wordAD, wordBQ, wordBD, wordCQ, wordCD;
    logic [2:0]     gmrHiQ, gmrHiD, gmrLoQ, gmrLoD, topQ, topD;

    logic [KEY_W-1:0]  tableData [PAGES];
    logic [KEY_W-1:0]  tableMask [PAGES];
    logic [HALF_W-1:0] gmrMem    [GMR_PAIRS];
    wsc_addr_t         resAddrQ  [RESULT_REGS];
    logic              resHitQ   [RESULT_REGS];

    wsc_pipe_t pipeQ [PIPE_DEPTH];
    wsc_pipe_t pipeD [PIPE_DEPTH];
    wsc_flag_t flagQ [FLAG_DEPTH];
    wsc_flag_t flagD [FLAG_DEPTH];

    wsc_addr_t sramAddrQ, sramAddrD;
    logic      sramDrvQ, sramDrvD, flagDrvQ, flagDrvD, successQ, successD;

    logic             wordA, searchDone, ownHit, upstreamHit, win, missAll;
    logic [KEY_W-1:0] key, globalMask;
    logic [PAGE_W-1:0] winPage;
    wsc_pipe_t        sel;
    wsc_flag_t        flagIn, flagTap;

    function automatic int latencyOf(input logic [1:0] size);
        case (size)
            TABLE_SIZE_SEL_ONE:   latencyOf = LAT_ONE;
            TABLE_SIZE_SEL_BLOCK: latencyOf = LAT_BLOCK;
            default:    latencyOf = LAT_FULL;
        endcase
    endfunction : latencyOf

    function automatic logic pageMatch(input logic [KEY_W-1:0] k, input logic [KEY_W-1:0] d,
                                       input logic [KEY_W-1:0] m, input logic [KEY_W-1:0] g);
        pageMatch = (((k ^ d) & ~m & ~g) == '0);
    endfunction : pageMatch

    // Cycle A is a valid search code with bit 2 high.
    assign wordA = link.commandValid && link.command[CODE_LSB +: 2] == SEARCH_CODE
                   && link.command[WIDE_BIT] && widthCfg == WIDE_CFG;

    always_comb begin
        stateD = stateQ;
        wordAD = wordAQ;
        wordBD = wordBQ;
        wordCD = wordCQ;
        gmrHiD = gmrHiQ;
        gmrLoD = gmrLoQ;
        topD   = topQ;
        searchDone = 1'b0;
        case (stateQ)
            S_IDLE: begin
                if (wordA) begin
                    wordAD = link.dataBus;
                    gmrHiD = link.command[GMR_LSB +: 3];
                    stateD = S_WORD_B;
                end
            end
            S_WORD_B: begin
                wordBD = link.dataBus;
                stateD = link.commandValid ? S_WORD_C : S_IDLE;
            end
            S_WORD_C: begin
                wordCD = link.dataBus;
                gmrLoD = link.command[GMR_LSB +: 3];
                topD   = link.command[TOP_LSB +: 3];
                stateD = link.commandValid ? S_WORD_D : S_IDLE;
            end
            S_WORD_D: begin
                // Bits 5:2 of this cycle are never looked at and no key is kept.
                searchDone = link.commandValid;
                stateD     = S_IDLE;
            end
            default: stateD = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateQ <= S_IDLE;
            wordAQ <= '0;
            wordBQ <= '0;
            wordCQ <= '0;
            gmrHiQ <= '0;
            gmrLoQ <= '0;
            topQ   <= '0;
        end else begin
            stateQ <= stateD;
            wordAQ <= wordAD;
            wordBQ <= wordBD;
            wordCQ <= wordCD;
            gmrHiQ <= gmrHiD;
            gmrLoQ <= gmrLoD;
            topQ   <= topD;
        end
    end

    always_ff @(posedge clk) begin
        if (entryWrite) begin
            tableData[entryPage] <= entryData;
            tableMask[entryPage] <= entryMask;
        end
        if (gmrWrite) begin
            gmrMem[gmrIndex] <= gmrData;
        end
    end

    // Compare in cycle D, when the last key word is on the bus.
    always_comb begin
        key        = {wordAQ, wordBQ, wordCQ, link.dataBus};
        globalMask = {gmrMem[gmrHiQ], gmrMem[gmrLoQ]};
        ownHit     = 1'b0;
        winPage    = '0;
        for (int p = PAGES - 1; p >= 0; p--) begin
            if (pageMatch(key, tableData[p], tableMask[p], globalMask)) begin
                ownHit  = 1'b1;
                winPage = PAGE_W'(p);
            end
        end
    end

    // Pipeline entry is made at the end of the C/D period; stages advance every clock.
    always_comb begin
        pipeD[0].valid = searchDone;
        pipeD[0].hit   = searchDone && ownHit;
        pipeD[0].addr  = {topQ, (INDEX_W - PAGE_W - 2)'(0), winPage, PAGE_POS0};
        for (int s = 1; s < PIPE_DEPTH; s++) begin
            pipeD[s] = pipeQ[s-1];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int s = 0; s < PIPE_DEPTH; s++) begin
                pipeQ[s] <= '0;
            end
            for (int r = 0; r < RESULT_REGS; r++) begin
                resAddrQ[r] <= '0;
                resHitQ[r]  <= 1'b0;
            end
        end else begin
            for (int s = 0; s < PIPE_DEPTH; s++) begin
                pipeQ[s] <= pipeD[s];
            end
            if (searchDone) begin
                resAddrQ[link.command[TOP_LSB +: 3]] <= pipeD[0].addr;
                resHitQ[link.command[TOP_LSB +: 3]]  <= ownHit;
            end
        end
    end

    assign resultAddr = resAddrQ[resultSel];
    assign resultHit  = resHitQ[resultSel];

    // The search occupies two stages, one device clock, at the selected latency.
    always_comb begin
        sel = pipeQ[PHASES * latencyOf(tableSizeSel) - 1];
        if (!sel.valid) begin
            sel = pipeQ[PHASES * latencyOf(tableSizeSel)];
        end
    end

    // Arbitration: upstream devices in the block, then upstream blocks.
    always_comb begin
        upstreamHit = (tableSizeSel != TABLE_SIZE_SEL_ONE && localHitIn)
                      || (tableSizeSel == TABLE_SIZE_SEL_FULL && blockHitIn);
        localHitOut = sel.valid && sel.hit;
        blockHitOut = sel.valid && (sel.hit || localHitIn);
        win         = sel.valid && sel.hit && !upstreamHit;
        missAll     = sel.valid && !sel.hit && !upstreamHit;
        flagIn.drive   = win || (missAll && defaultFlagDriver);
        flagIn.success = win;
        flagD[0]       = flagIn;
        for (int s = 1; s < FLAG_DEPTH; s++) begin
            flagD[s] = flagQ[s-1];
        end
        flagTap = (hitLatencySel == '0) ? flagIn : flagQ[PHASES * int'(hitLatencySel) - 1];
        sramDrvD  = win || (missAll && defaultSramDriver);
        sramAddrD = sel.valid ? sel.addr : sramAddrQ;
        flagDrvD  = flagTap.drive;
        successD  = flagTap.success;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int s = 0; s < FLAG_DEPTH; s++) begin
                flagQ[s] <= '0;
            end
            sramAddrQ <= '0;
            sramDrvQ  <= 1'b0;
            flagDrvQ  <= 1'b0;
            successQ  <= 1'b0;
        end else begin
            for (int s = 0; s < FLAG_DEPTH; s++) begin
                flagQ[s] <= flagD[s];
            end
            sramAddrQ <= sramAddrD;
            sramDrvQ  <= sramDrvD;
            flagDrvQ  <= flagDrvD;
            successQ  <= successD;
        end
    end

    assign link.sramAddressOut   = sramAddrQ;
    assign link.sramDriveEn      = sramDrvQ;
    assign link.sramCeN          = !sramDrvQ;
    assign link.sramAleN         = !sramDrvQ;
    assign link.sramWeN          = 1'b1;
    assign link.flagDriveEn      = flagDrvQ;
    assign link.searchValidOut   = flagDrvQ;
    assign link.searchSuccessOut = successQ;
endmodule : wsc_device

// *** hdl/wsc_host.sv ***
// Host end: issues four-cycle 272-bit search commands and collects the flags.
// Assumes the device's flag pins are resolved onto the link by the bench.
`timescale 1ns/100ps
module wsc_host
    import wsc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    wsc_link_if.host                  link,
    input  wire logic                 searchReq,
    output logic                      searchReady,
    input  wire logic [KEY_W-1:0]     searchKey,
    input  wire logic [2:0]           gmrHiSel,
    input  wire logic [2:0]           gmrLoSel,
    input  wire logic [2:0]           addrTop,
    input  wire logic [2:0]           resultIndex,
    output logic                      resultValid,
    output logic                      resultSuccess
);
    import wsc_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_WORD_A, H_WORD_B, H_WORD_C, H_WORD_D} wsc_host_state_t;

    wsc_host_state_t  stateQ, stateD;
    logic [KEY_W-1:0] keyQ, keyD;
    logic [2:0]       loQ, loD, topQ, topD, idxQ, idxD;
    logic             cmdvQ, cmdvD, validQ, validD, successQ, successD, seenQ;
    wsc_cmd_t         cmdQ, cmdD;
    wsc_word_t        dqQ, dqD;

    // A new search may start in the cycle that drives word D.
    assign searchReady = (stateQ == H_IDLE) || (stateQ == H_WORD_D);

    always_comb begin
        stateD = stateQ;
        keyD   = keyQ;
        loD    = loQ;
        topD   = topQ;
        idxD   = idxQ;
        cmdvD  = 1'b0;
        cmdD   = '0;
        dqD    = '0;
        if (searchReady && searchReq) begin
            keyD   = searchKey;
            loD    = gmrLoSel;
            topD   = addrTop;
            idxD   = resultIndex;
            cmdvD  = 1'b1;
            cmdD   = {3'h0, gmrHiSel, 1'b1, SEARCH_CODE};
            dqD    = searchKey[KEY_W-1 -: DQ_W];
            stateD = H_WORD_A;
        end else begin
            case (stateQ)
                H_WORD_A: begin
                    cmdvD  = 1'b1;
                    cmdD   = {7'h00, SEARCH_CODE};
                    dqD    = keyQ[KEY_W-DQ_W-1 -: DQ_W];
                    stateD = H_WORD_B;
                end
                H_WORD_B: begin
                    cmdvD  = 1'b1;
                    cmdD   = {topQ, loQ, 1'b0, SEARCH_CODE};
                    dqD    = keyQ[HALF_W-1 -: DQ_W];
                    stateD = H_WORD_C;
                end
                H_WORD_C: begin
                    cmdvD  = 1'b1;
                    cmdD   = {idxQ, 4'h0, SEARCH_CODE};
                    dqD    = keyQ[DQ_W-1:0];
                    stateD = H_WORD_D;
                end
                H_WORD_D: stateD = H_IDLE;
                H_IDLE:   stateD = H_IDLE;
                default:  stateD = H_IDLE;
            endcase
        end
    end

    // A result is taken on the first cycle of each driven valid flag.
    always_comb begin
        validD   = link.flagDriveEn && link.searchValidOut && !seenQ;
        successD = (link.flagDriveEn && link.searchValidOut) ? link.searchSuccessOut
                                                             : successQ;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateQ   <= H_IDLE;
            keyQ     <= '0;
            loQ      <= '0;
            topQ     <= '0;
            idxQ     <= '0;
            cmdvQ    <= 1'b0;
            cmdQ     <= '0;
            dqQ      <= '0;
            validQ   <= 1'b0;
            successQ <= 1'b0;
            seenQ    <= 1'b0;
        end else begin
            stateQ   <= stateD;
            keyQ     <= keyD;
            loQ      <= loD;
            topQ     <= topD;
            idxQ     <= idxD;
            cmdvQ    <= cmdvD;
            cmdQ     <= cmdD;
            dqQ      <= dqD;
            validQ   <= validD;
            successQ <= successD;
            seenQ    <= link.flagDriveEn && link.searchValidOut;
        end
    end

    assign link.commandValid = cmdvQ;
    assign link.command      = cmdQ;
    assign link.dataBus      = dqQ;
    assign resultValid       = validQ;
    assign resultSuccess     = successQ;
endmodule : wsc_host

// *** hdl/wsc_link_if.sv ***
// Command, data and result pins between the host end and one search device.
// Assumes the bench resolves the shared SRAM and flag wires from the enables.
`timescale 1ns/100ps
interface wsc_link_if;
    import wsc_pkg::*;
    logic      commandValid;
    wsc_cmd_t  command;
    wsc_word_t dataBus;
    wsc_addr_t sramAddressOut;
    logic      sramDriveEn;
    logic      sramCeN;
    logic      sramAleN;
    logic      sramWeN;
    logic      searchValidOut;
    logic      searchSuccessOut;
    logic      flagDriveEn;

    modport device (
        input  commandValid, command, dataBus,
        output sramAddressOut, sramDriveEn, sramCeN, sramAleN, sramWeN,
        output searchValidOut, searchSuccessOut, flagDriveEn
    );
    modport host (
        output commandValid, command, dataBus,
        input  sramAddressOut, sramDriveEn, searchValidOut, searchSuccessOut, flagDriveEn
    );
endinterface : wsc_link_if

// *** hdl/wsc_pkg.sv ***
// Constants and types shared by both ends of the wide search cascade link.
// Assumes one 40 MHz-class command clock, where each device clock is two command cycles.
package wsc_pkg;
    localparam int          CMD_W          = 9;
    localparam int          DQ_W           = 68;
    localparam int          KEY_W          = 272;
    localparam int          HALF_W         = 136;
    localparam int          SRAM_ADDRESS_OUT_W         = 22;
    localparam int          SRAM_ADDRESS_OUT_HI_LSB    = 19;
    localparam int          INDEX_W        = 19;
    localparam int          CODE_LSB       = 0;
    localparam int          WIDE_BIT       = 2;
    localparam int          GMR_LSB        = 3;
    localparam int          TOP_LSB        = 6;
    localparam logic [1:0]  SEARCH_CODE    = 2'h2;
    localparam logic [1:0]  TABLE_SIZE_SEL_ONE       = 2'h0;
    localparam logic [1:0]  TABLE_SIZE_SEL_BLOCK     = 2'h1;
    localparam logic [1:0]  TABLE_SIZE_SEL_FULL      = 2'h2;
    localparam int          LAT_ONE        = 4;
    localparam int          LAT_BLOCK      = 5;
    localparam int          LAT_FULL       = 6;
    localparam int          HIT_LATENCY_SEL_MAX       = 7;
    localparam int          PHASES         = 2;
    localparam int          PIPE_DEPTH     = LAT_FULL * PHASES + 1;
    localparam int          FLAG_DEPTH     = HIT_LATENCY_SEL_MAX * PHASES;
    localparam int          PAGES          = 16;
    localparam int          PAGE_W         = 4;
    localparam logic [1:0]  PAGE_POS0      = 2'h0;
    localparam int          GMR_PAIRS      = 8;
    localparam int          RESULT_REGS    = 8;
    localparam logic [7:0]  WIDE_CFG       = 8'haa;

    typedef logic [CMD_W-1:0]  wsc_cmd_t;
    typedef logic [DQ_W-1:0]   wsc_word_t;
    typedef logic [SRAM_ADDRESS_OUT_W-1:0] wsc_addr_t;

    typedef struct packed {
        logic      valid;
        logic      hit;
        wsc_addr_t addr;
    } wsc_pipe_t;

    typedef struct packed {
        logic drive;
        logic success;
    } wsc_flag_t;
endpackage : wsc_pkg

// *** sim/wsc_props.sv ***
// Concurrent checks on the link between the host end and one search device.
// Assumes a single device that is also the default driver, watched beside the interface.
`timescale 1ns/100ps
module wsc_props
    import wsc_pkg::*;
(
    input logic                clk,
    input logic                rst_n,
    input logic                commandValid,
    input wsc_pkg::wsc_cmd_t   command,
    input wsc_pkg::wsc_addr_t  sramAddressOut,
    input logic                sramDriveEn,
    input logic                sramCeN,
    input logic                sramAleN,
    input logic                sramWeN,
    input logic                searchValidOut,
    input logic                searchSuccessOut,
    input logic                flagDriveEn,
    input logic [1:0]          tableSizeSel,
    input logic [2:0]          hitLatencySel,
    input logic                localHitIn
);
    logic [1:0]  phase_q;
    logic [1:0]  phase_d;
    logic        drivePrev_q;
    logic [13:0] roseHist_q;
    logic [13:0] roseHist_d;
    logic        roseNow;
    logic [14:0] roseAll;
    logic        phaseA;
    logic        phaseC;
    logic        phaseD;

    // Phase counter wraps every four command cycles so back-to-back searches stay aligned.
    always_comb begin
        phase_d = commandValid ? phase_q + 2'h1 : 2'h0;
        roseNow = sramDriveEn && !drivePrev_q;
        roseAll = {roseHist_q, roseNow};
        roseHist_d = roseAll[13:0];
        phaseA = commandValid && (phase_q == 2'h0);
        phaseC = commandValid && (phase_q == 2'h2);
        phaseD = commandValid && (phase_q == 2'h3);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
            drivePrev_q <= 1'b0;
            roseHist_q <= '0;
        end else begin
            phase_q <= phase_d;
            drivePrev_q <= sramDriveEn;
            roseHist_q <= roseHist_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property pTop;
        logic [2:0] top;
        (phaseC && tableSizeSel == TABLE_SIZE_SEL_ONE, top = command[TOP_LSB +: 3])
            |-> ##10 sramDriveEn && sramAddressOut[SRAM_ADDRESS_OUT_W-1 -: 3] == top;
    endproperty

    AST_LAT_ONE: assert property (phaseD && tableSizeSel == TABLE_SIZE_SEL_ONE |->
        ##8 !sramDriveEn ##1 sramDriveEn [*2] ##1 !sramDriveEn) else $error("latency one");
    AST_LAT_BLOCK: assert property (phaseD && !localHitIn
        && tableSizeSel == TABLE_SIZE_SEL_BLOCK |-> ##10 !sramDriveEn ##1 sramDriveEn [*2] ##1 !sramDriveEn)
        else $error("latency block");
    AST_LAT_FULL: assert property (phaseD && tableSizeSel == TABLE_SIZE_SEL_FULL |->
        ##12 !sramDriveEn ##1 sramDriveEn [*2] ##1 !sramDriveEn) else $error("latency full");
    AST_FLAG_SHIFT: assert property ($rose(flagDriveEn) |->
        roseAll[{hitLatencySel, 1'b0}]) else $error("flag shift wrong");
    AST_FLAG_PAIR: assert property ($rose(flagDriveEn) |=>
        flagDriveEn ##1 !flagDriveEn) else $error("flag width wrong");
    AST_TOP_BITS: assert property (pTop) else $error("top address bits wrong");
    AST_PAGE_POS: assert property (sramDriveEn |->
        sramAddressOut[1:0] == PAGE_POS0) else $error("page position not zero");
    AST_CMD_A: assert property (phaseA |->
        command[1:0] == SEARCH_CODE && command[WIDE_BIT]) else $error("cycle A bad");
    AST_CMD_C: assert property (phaseC |->
        command[1:0] == SEARCH_CODE && !command[WIDE_BIT]) else $error("cycle C bad");
    AST_CMD_RUN: assert property ($rose(commandValid) |->
        commandValid [*4]) else $error("command run short");
    AST_STROBES: assert property (sramCeN == !sramDriveEn && sramAleN == !sramDriveEn
        && sramWeN) else $error("strobes wrong");
    AST_FLAG_VALID: assert property (flagDriveEn |-> searchValidOut)
        else $error("valid low while driven");

    cover property (phaseD && tableSizeSel == TABLE_SIZE_SEL_FULL);
    cover property (flagDriveEn && !searchSuccessOut);
    cover property (phaseD ##1 phaseA);
endmodule : wsc_props

// *** sim/wsc_tb.sv ***
// Self-checking bench: host end and one search device joined through the link interface.
// Assumes the device is the only and last device of its table.
`timescale 1ns/100ps
module wsc_tb;
    import wsc_pkg::*;
    logic               clk;
    logic               rst_n;
    logic               searchReq;
    logic               searchReady;
    logic [KEY_W-1:0]   searchKey;
    logic [2:0]         gmrHiSel;
    logic [2:0]         gmrLoSel;
    logic [2:0]         addrTop;
    logic [2:0]         resultIndex;
    logic               resultValid;
    logic               resultSuccess;
    logic [1:0]         tableSizeSel;
    logic [2:0]         hitLatencySel;
    logic               defaultSramDriver;
    logic               defaultFlagDriver;
    logic               localHitIn;
    logic               blockHitIn;
    logic               localHitOut;
    logic [7:0]         widthCfg;
    int                 nLho = 0;
    logic               entryWrite;
    logic [PAGE_W-1:0]  entryPage;
    logic [KEY_W-1:0]   entryData;
    logic [KEY_W-1:0]   entryMask;
    logic               gmrWrite;
    logic [2:0]         gmrIndex;
    logic [HALF_W-1:0]  gmrData;
    logic [2:0]         resultSel;
    wsc_addr_t          resultAddr;
    logic               resultHit;
    logic [KEY_W-1:0]   kA;
    logic [KEY_W-1:0]   kB;
    logic [KEY_W-1:0]   kU;
    logic [KEY_W-1:0]   kL;
    logic [2:0]         hl [3] = '{3'h0, 3'h3, 3'h7};
    logic               resQ [$];
    int                 n_mismatch = 0;
    int                 n_compared = 0;

    wsc_link_if link ();
    wsc_host wsc_host_inst (.clk(clk), .rst_n(rst_n), .link(link.host), .searchReq(searchReq),
        .searchReady(searchReady), .searchKey(searchKey), .gmrHiSel(gmrHiSel),
        .gmrLoSel(gmrLoSel), .addrTop(addrTop), .resultIndex(resultIndex),
        .resultValid(resultValid), .resultSuccess(resultSuccess));
    wsc_device wsc_device_inst (.clk(clk), .rst_n(rst_n), .link(link.device),
        .tableSizeSel(tableSizeSel), .hitLatencySel(hitLatencySel), .widthCfg(widthCfg),
        .defaultSramDriver(defaultSramDriver), .defaultFlagDriver(defaultFlagDriver),
        .localHitIn(localHitIn), .blockHitIn(blockHitIn), .localHitOut(localHitOut),
        .blockHitOut(), .entryWrite(entryWrite), .entryPage(entryPage), .entryData(entryData),
        .entryMask(entryMask), .gmrWrite(gmrWrite), .gmrIndex(gmrIndex), .gmrData(gmrData),
        .resultSel(resultSel), .resultAddr(resultAddr), .resultHit(resultHit));
    wsc_props wsc_props_inst (.clk(clk), .rst_n(rst_n), .commandValid(link.commandValid),
        .command(link.command), .sramAddressOut(link.sramAddressOut),
        .sramDriveEn(link.sramDriveEn), .sramCeN(link.sramCeN), .sramAleN(link.sramAleN),
        .sramWeN(link.sramWeN), .searchValidOut(link.searchValidOut),
        .searchSuccessOut(link.searchSuccessOut), .flagDriveEn(link.flagDriveEn),
        .tableSizeSel(tableSizeSel), .hitLatencySel(hitLatencySel), .localHitIn(localHitIn));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Flop outputs are read before this edge updates them, so each pulse is taken once.
    always @(posedge clk) begin
        if (resultValid === 1'b1) begin
            resQ.push_back(resultSuccess);
        end
        if (localHitOut === 1'b1) nLho++;
    end

    function automatic logic [KEY_W-1:0] mkKey(input logic [15:0] n);
        return {17{n}};
    endfunction : mkKey

    function automatic wsc_addr_t expAddr(input logic [2:0] top, input logic [3:0] page);
        return {top, 13'h0000, page, 2'h0};
    endfunction : expAddr

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk1

    task automatic chkAddr(input wsc_addr_t got, input wsc_addr_t exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chkAddr

    task automatic writeEntry(input logic [3:0] page, input logic [KEY_W-1:0] d, m);
        entryWrite <= 1'b1;
        entryPage <= page;
        entryData <= d;
        entryMask <= m;
        @(posedge clk);
        entryWrite <= 1'b0;
        @(posedge clk);
    endtask : writeEntry

    task automatic writeGmr(input logic [2:0] idx, input logic [HALF_W-1:0] d);
        gmrWrite <= 1'b1;
        gmrIndex <= idx;
        gmrData <= d;
        @(posedge clk);
        gmrWrite <= 1'b0;
        @(posedge clk);
    endtask : writeGmr

    // Request stays up on return so that the next call follows back to back.
    task automatic search(input logic [KEY_W-1:0] key, input logic [2:0] hi, lo, top, idx);
        searchReq <= 1'b1;
        searchKey <= key;
        gmrHiSel <= hi;
        gmrLoSel <= lo;
        addrTop <= top;
        resultIndex <= idx;
        @(negedge clk);
        for (int i = 0; i < 20 && searchReady !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
    endtask : search

    task automatic idle;
        searchReq <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : idle

    task automatic getRes(input logic exp);
        for (int i = 0; i < 100 && resQ.size() == 0; i++) @(posedge clk);
        chk1(resQ.size() != 0, 1'b1, "result seen");
        if (resQ.size() != 0) chk1(resQ.pop_front(), exp, "success");
    endtask : getRes

    task automatic chkReg(input logic [2:0] idx, input logic hit, input wsc_addr_t addr);
        resultSel <= idx;
        @(negedge clk);
        chk1(resultHit, hit, "stored hit");
        if (hit) chkAddr(resultAddr, addr, "stored address");
        @(posedge clk);
    endtask : chkReg

    initial begin
        repeat (20000) @(posedge clk);
        $display("watchdog expired");
        n_mismatch++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        {searchReq, searchKey, gmrHiSel, gmrLoSel, addrTop, resultIndex} = '0;
        {tableSizeSel, hitLatencySel, localHitIn, blockHitIn, resultSel} = '0;
        {entryWrite, entryPage, entryData, entryMask, gmrWrite, gmrIndex, gmrData} = '0;
        defaultSramDriver = 1'b1;
        defaultFlagDriver = 1'b1;
        widthCfg = WIDE_CFG;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        writeGmr(3'h0, '0);
        writeGmr(3'h5, '1);
        for (int p = 0; p < PAGES; p++) writeEntry(4'(p), mkKey(16'h1000 + 16'(p)), '0);
        for (int s = 0; s < 3; s++) begin
            // Config is static in the device, so the flag pipe drains before it changes.
            repeat (14) @(posedge clk);
            tableSizeSel <= 2'(s);
            hitLatencySel <= hl[s];
            repeat (2) @(posedge clk);
            search(mkKey(16'h1004 + 16'(s)), 3'h0, 3'h0, 3'(s + 1), 3'(s));
            idle();
            getRes(1'b1);
            chkReg(3'(s), 1'b1, expAddr(3'(s + 1), 4'(4 + s)));
        end
        $display("test latency sweep done");
        tableSizeSel <= TABLE_SIZE_SEL_ONE;
        hitLatencySel <= 3'h1;
        kA = mkKey(16'hdead);
        kB = mkKey(16'h1007);
        kU = {kA[KEY_W-1:HALF_W], kB[HALF_W-1:0]};
        kB = mkKey(16'h1009);
        kL = {kB[KEY_W-1:HALF_W], kA[HALF_W-1:0]};
        repeat (2) @(posedge clk);
        search(kU, 3'h5, 3'h0, 3'h2, 3'h3);
        search(kU, 3'h0, 3'h0, 3'h2, 3'h4);
        search(kL, 3'h0, 3'h5, 3'h2, 3'h5);
        idle();
        getRes(1'b1);
        getRes(1'b0);
        getRes(1'b1);
        chkReg(3'h3, 1'b1, expAddr(3'h2, 4'h7));
        chkReg(3'h4, 1'b0, '0);
        chkReg(3'h5, 1'b1, expAddr(3'h2, 4'h9));
        $display("test back to back masks done");
        writeEntry(4'h2, '0, '1);
        search(mkKey(16'h100b), 3'h0, 3'h0, 3'h6, 3'h6);
        idle();
        getRes(1'b1);
        chkReg(3'h6, 1'b1, expAddr(3'h6, 4'h2));
        tableSizeSel <= TABLE_SIZE_SEL_BLOCK;
        localHitIn <= 1'b1;
        search(mkKey(16'h100b), 3'h0, 3'h0, 3'h6, 3'h7);
        idle();
        repeat (20) @(posedge clk);
        chk1(resQ.size() == 0, 1'b1, "yield");
        chk1(nLho == 14, 1'b1, "local hit cycles");
        chkReg(3'h7, 1'b1, expAddr(3'h6, 4'h2));
        $display("test lowest match done");
        stop_test();
    end
endmodule : wsc_tb
